// file: smsp_pkg.sv
// Purpose: shared constants and types of the master/slave serial port
// Assumes: 8-bit words, four chip selects, one 10 MHz clock
// Notes: chip-select configuration travels as one packed struct per select
package smsp_pkg;
    localparam int SMSP_WORD_BITS = 8;
    localparam int SMSP_NUM_CS = 4;
    localparam int SMSP_DIV_BITS = 8;
    localparam logic [3:0] SMSP_WORD_EDGES = 4'H8;
    localparam logic [SMSP_DIV_BITS-1:0] SMSP_DIV_ONE = 8'H01;
    localparam logic [SMSP_DIV_BITS-1:0] SMSP_DIV_RST = 8'H00;
    localparam logic [SMSP_WORD_BITS-1:0] SMSP_DATA_RST = 8'H00;
    localparam logic [4:0] SMSP_HALF_RST = 5'H00;
    localparam logic [4:0] SMSP_LEAD_HALVES = 5'H02;
    localparam logic [4:0] SMSP_WORD_HALVES = 5'H10;
    localparam logic [SMSP_NUM_CS-1:0] SMSP_CS_IDLE = 4'HF;

    // bit 2 position of the per-select release setting, kept only for layout
    localparam int SMSP_CS_RELEASE_BIT = 2;

    typedef struct packed {
        logic [SMSP_DIV_BITS-1:0] serial_clock_divider;
        logic cs_release_between_words;
        logic clock_phase_setting;
        logic clock_polarity_setting;
    } smsp_cs_cfg_s;

    typedef enum logic [2:0] {
        SMSP_M_IDLE = 3'H1,
        SMSP_M_LEAD = 3'H2,
        SMSP_M_XFER = 3'H4
    } smsp_mstate_e;
endpackage : smsp_pkg

// file: smsp_port.sv
// Purpose: serial peripheral port, master or slave, with its known quirks kept
// Assumes: pins sck_in, mosi_in, miso_in, nss_in are asynchronous to clk_in
// Notes: slave logic samples the synchronised clock, so sck must be slow
`timescale 1ns/1ns
`default_nettype none

// Function
// - slave transmit underflow is never flagged; the old shift contents go out.
// - disable command is ignored while in slave mode; port stays active.
// - mixed divider one and other, polarity 1 phase 0, multi-select: extra sck pulse.
// - slave enable or first transfer may raise receive-full falsely.
// - per-select release-between-words bit is not implemented; it is ignored.
module smsp_port
    import smsp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic enable_in,
    input wire logic disable_in,
    input wire logic soft_reset_in,
    input wire logic master_mode_in,
    input wire smsp_cs_cfg_s [SMSP_NUM_CS-1:0] cs_config_in,
    input wire logic [SMSP_NUM_CS-1:0] cs_in_use_in,
    input wire logic [1:0] cs_select_in,
    input wire logic tx_write_in,
    input wire logic [SMSP_WORD_BITS-1:0] tx_data_in,
    input wire logic rx_read_in,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic nss_in,
    output logic port_enabled_out,
    output logic tx_empty_out,
    output logic receive_full_flag_out,
    output logic [SMSP_WORD_BITS-1:0] receive_holding_register_out,
    output logic sck_out,
    output logic mosi_out,
    output logic [SMSP_NUM_CS-1:0] cs_n_out,
    output logic miso_out,
    output logic miso_oe_n_out
);
    // ==========================================================
    // reset release and pin synchronisers
    logic [1:0] rst_sync_q;
    logic rst_b;
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic sck_prev_q;
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_sync_q <= 2'H0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'B1};
        end
    end
    assign rst_b = rst_sync_q[1];

    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_meta_q <= 4'HF;
            pin_sync_q <= 4'HF;
            sck_prev_q <= 1'B1;
        end
        else
        begin
            pin_meta_q <= {nss_in, miso_in, mosi_in, sck_in};
            pin_sync_q <= pin_meta_q;
            sck_prev_q <= pin_sync_q[0];
        end
    end

    logic s_sck;
    logic s_mosi;
    logic s_miso;
    logic s_nss;
    assign s_sck = pin_sync_q[0];
    assign s_mosi = pin_sync_q[1];
    assign s_miso = pin_sync_q[2];
    assign s_nss = pin_sync_q[3];

    // ==========================================================
    // extra-pulse condition across the selects in use
    logic [SMSP_NUM_CS-1:0] div_is_one;
    logic [SMSP_NUM_CS-1:0] div_not_one;
    for (genvar g = 0; g < SMSP_NUM_CS; g++)
    begin : g_cs
        assign div_is_one[g] = cs_in_use_in[g] && (cs_config_in[g].serial_clock_divider == SMSP_DIV_ONE);
        assign div_not_one[g] = cs_in_use_in[g] && (cs_config_in[g].serial_clock_divider != SMSP_DIV_ONE);
    end

    smsp_cs_cfg_s cur_cfg;
    smsp_cs_cfg_s slv_cfg;
    logic extra_pulse;
    logic [SMSP_DIV_BITS-1:0] half_div;
    assign cur_cfg = cs_config_in[cs_select_in];
    assign slv_cfg = cs_config_in[0];
    assign extra_pulse = (|div_is_one) && (|div_not_one) && cur_cfg.clock_polarity_setting
                         && !cur_cfg.clock_phase_setting;
    assign half_div = (cur_cfg.serial_clock_divider == SMSP_DIV_RST) ? SMSP_DIV_ONE
                      : cur_cfg.serial_clock_divider;

    // ==========================================================
    // port state
    smsp_mstate_e st_q, st_d;
    logic en_q, en_d;
    logic txf_q, txf_d;
    logic [SMSP_WORD_BITS-1:0] txh_q, txh_d;
    logic [SMSP_WORD_BITS-1:0] sh_tx_q, sh_tx_d;
    logic [SMSP_WORD_BITS-1:0] sh_rx_q, sh_rx_d;
    logic [SMSP_WORD_BITS-1:0] rxh_q, rxh_d;
    logic rxf_q, rxf_d;
    logic [3:0] bits_q, bits_d;
    logic [4:0] half_q, half_d;
    logic [SMSP_DIV_BITS-1:0] div_q, div_d;
    logic sck_q, sck_d;
    logic [SMSP_NUM_CS-1:0] csn_q, csn_d;
    logic armed_q, armed_d;
    logic pol_prev_q;
    logic nss_prev_q;

    logic s_rise;
    logic s_fall;
    logic s_lead;
    logic s_sample;
    assign s_rise = s_sck && !sck_prev_q;
    assign s_fall = !s_sck && sck_prev_q;
    assign s_lead = slv_cfg.clock_polarity_setting ? s_fall : s_rise;

    always_comb
    begin
        st_d = st_q;
        en_d = en_q;
        txf_d = txf_q;
        txh_d = txh_q;
        sh_tx_d = sh_tx_q;
        sh_rx_d = sh_rx_q;
        rxh_d = rxh_q;
        rxf_d = rxf_q;
        bits_d = bits_q;
        half_d = half_q;
        div_d = div_q;
        sck_d = sck_q;
        csn_d = csn_q;
        armed_d = armed_q;
        s_sample = 1'B0;

        if (rx_read_in)
        begin
            rxf_d = 1'B0;
        end
        if (tx_write_in)
        begin
            txh_d = tx_data_in;
            txf_d = 1'B1;
        end
        if (enable_in)
        begin
            en_d = 1'B1;
            if (!master_mode_in)
            begin
                rxf_d = 1'B1;
                armed_d = 1'B1;
            end
        end
        if (disable_in && master_mode_in)
        begin
            en_d = 1'B0;
        end
        // a polarity flip after enabling disarms the glitch
        if (slv_cfg.clock_polarity_setting != pol_prev_q)
        begin
            armed_d = 1'B0;
        end

        if (!master_mode_in)
        begin
            sck_d = slv_cfg.clock_polarity_setting;
            csn_d = SMSP_CS_IDLE;
            st_d = SMSP_M_IDLE;
            if (s_nss || !en_q)
            begin
                bits_d = 4'H0;
            end
            else
            begin
                if (nss_prev_q)
                begin
                    // no new data: shift register keeps its old shifted contents, nothing is reported
                    if (txf_d)
                    begin
                        sh_tx_d = txh_d;
                        txf_d = 1'B0;
                    end
                end
                s_sample = slv_cfg.clock_phase_setting ? !s_lead && (s_rise || s_fall) : s_lead;
                if (s_sample)
                begin
                    sh_rx_d = {sh_rx_q[SMSP_WORD_BITS-2:0], s_mosi};
                    bits_d = bits_q + 4'H1;
                    if (armed_q)
                    begin
                        rxf_d = 1'B1;
                        armed_d = 1'B0;
                    end
                    if (bits_q == SMSP_WORD_EDGES - 4'H1)
                    begin
                        rxh_d = {sh_rx_q[SMSP_WORD_BITS-2:0], s_mosi};
                        rxf_d = 1'B1;
                        bits_d = 4'H0;
                    end
                end
                else if ((s_rise || s_fall) && bits_q != 4'H0)
                begin
                    sh_tx_d = {sh_tx_q[SMSP_WORD_BITS-2:0], 1'B0};
                end
            end
        end
        else
        begin
            case (st_q)
                SMSP_M_IDLE:
                begin
                    sck_d = cur_cfg.clock_polarity_setting;
                    // release after a word unless the next one waits, then the select stays low; the per-select hold bit is not wired
                    csn_d = SMSP_CS_IDLE;
                    if (en_q && txf_q)
                    begin
                        sh_tx_d = txh_q;
                        txf_d = tx_write_in;
                        csn_d = ~(4'H1 << cs_select_in);
                        half_d = SMSP_HALF_RST;
                        bits_d = 4'H0;
                        div_d = half_div;
                        st_d = extra_pulse ? SMSP_M_LEAD : SMSP_M_XFER;
                    end
                end
                SMSP_M_LEAD:
                begin
                    div_d = div_q - SMSP_DIV_ONE;
                    if (div_q == SMSP_DIV_ONE)
                    begin
                        div_d = half_div;
                        sck_d = !sck_q;
                        half_d = half_q + 5'H01;
                        if (half_q == SMSP_LEAD_HALVES - 5'H01)
                        begin
                            half_d = SMSP_HALF_RST;
                            st_d = SMSP_M_XFER;
                        end
                    end
                end
                default:
                begin
                    div_d = div_q - SMSP_DIV_ONE;
                    if (div_q == SMSP_DIV_ONE)
                    begin
                        div_d = half_div;
                        sck_d = !sck_q;
                        half_d = half_q + 5'H01;
                        // even half index is a leading edge
                        if (half_q[0] == cur_cfg.clock_phase_setting)
                        begin
                            sh_rx_d = {sh_rx_q[SMSP_WORD_BITS-2:0], s_miso};
                            bits_d = bits_q + 4'H1;
                        end
                        else if (bits_q != 4'H0)
                        begin
                            sh_tx_d = {sh_tx_q[SMSP_WORD_BITS-2:0], 1'B0};
                        end
                        if (half_q == SMSP_WORD_HALVES - 5'H01)
                        begin
                            rxh_d = sh_rx_d;
                            rxf_d = 1'B1;
                            st_d = SMSP_M_IDLE;
                        end
                    end
                end
            endcase
        end

        if (soft_reset_in)
        begin
            // software stop path for a slave that ignores disable
            st_d = SMSP_M_IDLE;
            en_d = 1'B0;
            txf_d = 1'B0;
            rxf_d = 1'B0;
            armed_d = 1'B0;
            bits_d = 4'H0;
            sck_d = cur_cfg.clock_polarity_setting;
            csn_d = SMSP_CS_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= SMSP_M_IDLE;
            en_q <= 1'B0;
            txf_q <= 1'B0;
            txh_q <= SMSP_DATA_RST;
            sh_tx_q <= SMSP_DATA_RST;
            sh_rx_q <= SMSP_DATA_RST;
            rxh_q <= SMSP_DATA_RST;
            rxf_q <= 1'B0;
            bits_q <= 4'H0;
            half_q <= SMSP_HALF_RST;
            div_q <= SMSP_DIV_RST;
            sck_q <= 1'B0;
            csn_q <= SMSP_CS_IDLE;
            armed_q <= 1'B0;
            pol_prev_q <= 1'B0;
            nss_prev_q <= 1'B1;
        end
        else
        begin
            st_q <= st_d;
            en_q <= en_d;
            txf_q <= txf_d;
            txh_q <= txh_d;
            sh_tx_q <= sh_tx_d;
            sh_rx_q <= sh_rx_d;
            rxh_q <= rxh_d;
            rxf_q <= rxf_d;
            bits_q <= bits_d;
            half_q <= half_d;
            div_q <= div_d;
            sck_q <= sck_d;
            csn_q <= csn_d;
            armed_q <= armed_d;
            pol_prev_q <= slv_cfg.clock_polarity_setting;
            nss_prev_q <= s_nss;
        end
    end

    // ==========================================================
    // outputs
    assign port_enabled_out = en_q;
    assign tx_empty_out = !txf_q;
    assign receive_full_flag_out = rxf_q;
    assign receive_holding_register_out = rxh_q;
    assign sck_out = sck_q;
    assign mosi_out = sh_tx_q[SMSP_WORD_BITS-1];
    assign cs_n_out = csn_q;
    assign miso_out = sh_tx_q[SMSP_WORD_BITS-1];
    assign miso_oe_n_out = !(en_q && !master_mode_in && !s_nss);
endmodule : smsp_port

`default_nettype wire

// file: smsp_port_chk.sv
// Purpose: assertions on the port's enable, flag and chip-select outputs
// Assumes: bound to smsp_port, one clock domain
// Notes: the bench never pulses two commands in one cycle
`timescale 1ns/1ns
`default_nettype none
module smsp_port_chk
    import smsp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic enable_in,
    input wire logic disable_in,
    input wire logic soft_reset_in,
    input wire logic master_mode_in,
    input wire logic rx_read_in,
    input wire logic port_enabled_out,
    input wire logic receive_full_flag_out,
    input wire logic [SMSP_NUM_CS-1:0] cs_n_out,
    input wire logic miso_oe_n_out
);
    // ==========================================
    // command and flag relations
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_slave_on;
        port_enabled_out && !master_mode_in && !soft_reset_in;
    endsequence
    sequence s_master_off;
        port_enabled_out && master_mode_in && disable_in && !enable_in && !soft_reset_in;
    endsequence
    a_slave_disable_ignored: assert property (s_slave_on ##0 disable_in |=> port_enabled_out)
        else $error("slave disable took effect");
    a_master_disable_works: assert property (s_master_off |=> !port_enabled_out)
        else $error("master disable ignored");
    a_soft_reset_stops: assert property (soft_reset_in |=> !port_enabled_out && !receive_full_flag_out)
        else $error("soft reset left port running");
    a_enable_glitch_flag: assert property (!master_mode_in && enable_in && !soft_reset_in |=> receive_full_flag_out)
        else $error("slave enable did not raise flag");
    a_flag_stands: assert property (receive_full_flag_out && !rx_read_in && !soft_reset_in |=> receive_full_flag_out)
        else $error("receive flag dropped unread");
    a_miso_slave_only: assert property (!miso_oe_n_out |-> port_enabled_out && !master_mode_in)
        else $error("miso driven outside slave");
    a_cs_one_hot: assert property (cs_n_out != SMSP_CS_IDLE |-> $onehot(~cs_n_out) && master_mode_in)
        else $error("chip selects not one-hot");
    a_cs_idle_off: assert property (!port_enabled_out [*2] |-> cs_n_out == SMSP_CS_IDLE)
        else $error("chip select active while off");
endmodule : smsp_port_chk
bind smsp_port smsp_port_chk i_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .enable_in(enable_in),
    .disable_in(disable_in), .soft_reset_in(soft_reset_in), .master_mode_in(master_mode_in),
    .rx_read_in(rx_read_in), .port_enabled_out(port_enabled_out), .cs_n_out(cs_n_out),
    .receive_full_flag_out(receive_full_flag_out), .miso_oe_n_out(miso_oe_n_out));
`default_nettype wire

// file: smsp_peer.sv
// Purpose: far-side device, slave to the master port and master to the slave port
// Assumes: phase 0 only; frames it drives use a half period of 16 clocks
// Notes: a released data line shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module smsp_peer
    import smsp_pkg::*;
(
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic pol_in,
    input wire logic [SMSP_WORD_BITS-1:0] reply_in,
    output var logic miso_out,
    output var logic sck_out,
    output var logic mosi_out,
    output var logic nss_out,
    output var logic [SMSP_WORD_BITS-1:0] got_out
);
    logic [SMSP_WORD_BITS-1:0] sh;
    // ==========================================
    // slave role: msb first, sample leading, shift trailing
    initial
    begin
        {miso_out, sck_out, mosi_out, nss_out} = 4'H1;
        got_out = 8'H00;
    end
    always @(negedge cs_n_in)
    begin
        sh = reply_in;
        miso_out = sh[7];
    end
    always @(sck_in)
        if (!cs_n_in && sck_in != pol_in)
            got_out = {got_out[6:0], mosi_in};
        else if (!cs_n_in)
        begin
            sh = {sh[6:0], 1'b0};
            miso_out = sh[7];
        end
    always @(posedge cs_n_in)
        miso_out = ~miso_out;
    task automatic send(input logic [SMSP_WORD_BITS-1:0] b);
        nss_out = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            mosi_out = b[i];
            #1600 sck_out = 1'b1;
            got_out = {got_out[6:0], miso_in};
            #1600 sck_out = 1'b0;
        end
        #1600 nss_out = 1'b1;
        mosi_out = ~mosi_out;
    endtask : send
endmodule : smsp_peer
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench of the master/slave serial port
// Assumes: peer model on the serial pins, 10 MHz clock
// Notes: the mixed-divider words skip the data compare; at a divider of 1 the miso round trip is too slow
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import smsp_pkg::*;
    logic clk_in = 1'b0, rst_b_in = 1'b0, enable_in = 1'b0, disable_in = 1'b0, soft_reset_in = 1'b0;
    logic master_mode_in = 1'b1, tx_write_in = 1'b0, rx_read_in = 1'b0, peer_pol = 1'b0;
    logic [7:0] tx_data_in = 8'H00, reply = 8'H00, got, b, receive_holding_register_out;
    smsp_cs_cfg_s [3:0] cs_config_in = '0;
    logic [3:0] cs_in_use_in = 4'H1, cs_n_out;
    logic [1:0] cs_select_in = 2'H0;
    logic sck_in, mosi_in, miso_in, nss_in, port_enabled_out, tx_empty_out, receive_full_flag_out;
    logic sck_out, mosi_out, miso_out, miso_oe_n_out;
    int mismatches = 0, cmp_count = 0, edges = 0;
    initial forever #50 clk_in = ~clk_in;
    always @(sck_out) edges++;
    smsp_port i_dut (.clk_in, .rst_b_in, .enable_in, .disable_in, .soft_reset_in, .master_mode_in,
        .cs_config_in, .cs_in_use_in, .cs_select_in, .tx_write_in, .tx_data_in, .rx_read_in, .sck_in,
        .mosi_in, .miso_in, .nss_in, .port_enabled_out, .tx_empty_out, .receive_full_flag_out,
        .receive_holding_register_out, .sck_out, .mosi_out, .cs_n_out, .miso_out, .miso_oe_n_out);
    smsp_peer i_peer (.sck_in(sck_out), .cs_n_in(cs_n_out[cs_select_in]), .mosi_in(mosi_out),
        .miso_in(miso_out), .pol_in(peer_pol), .reply_in(reply), .miso_out(miso_in), .sck_out(sck_in),
        .mosi_out(mosi_in), .nss_out(nss_in), .got_out(got));
    // ==========================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask : pulse
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // 16 sck toggles a word, two more when divider kinds mix at polarity 1 phase 0
    function automatic logic [7:0] exp_edges();
        logic one = 1'b0;
        logic other = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            if (cs_in_use_in[k] && cs_config_in[k].serial_clock_divider == SMSP_DIV_ONE)
                one = 1'b1;
            else if (cs_in_use_in[k])
                other = 1'b1;
        end
        return (one && other && cs_config_in[cs_select_in][1:0] == 2'H1) ? 8'H12 : 8'H10;
    endfunction : exp_edges
    task automatic mword(input logic [7:0] tx, input logic [7:0] rp, input logic dchk);
        int i;
        reply = rp;
        peer_pol = cs_config_in[cs_select_in].clock_polarity_setting;
        tx_data_in = tx;
        tick(2);
        edges = 0;
        pulse(tx_write_in);
        for (i = 0; i < 3000 && receive_full_flag_out !== 1'b1; i++)
            tick(1);
        if (i == 3000)
        begin
            mismatches++;
            tally_and_finish();
        end
        check(8'(edges), exp_edges());
        if (dchk)
        begin
            check(receive_holding_register_out, rp);
            check(got, tx);
        end
        pulse(rx_read_in);
    endtask : mword
    // ==========================================
    // main sequence
    initial
    begin
        void'($urandom(32'H0C570736));
        tick(3);
        rst_b_in = 1'b1;
        tick(3);
        pulse(enable_in);
        for (int k = 0; k < 4; k++)
        begin
            cs_select_in = 2'($urandom_range(3));
            cs_in_use_in = 4'H1 << cs_select_in;
            cs_config_in[cs_select_in] = {8'($urandom_range(6, 4)), 1'($urandom), 1'b0, 1'($urandom)};
            mword(8'($urandom), 8'($urandom), 1'b1);
        end
        $display("test master_words done");
        cs_select_in = 2'H0;
        cs_in_use_in = 4'H3;
        cs_config_in[0] = {8'H04, 3'H1};
        cs_config_in[1] = {8'H01, 3'H1};
        mword(8'H5A, 8'HC3, 1'b0);
        cs_config_in[0] = {8'H01, 3'H1};
        mword(8'HA5, 8'H3C, 1'b0);
        // phase 1 with mixed dividers must not add the extra pulse
        cs_config_in[0] = {8'H04, 3'H3};
        mword(8'H96, 8'H69, 1'b0);
        pulse(disable_in);
        check(8'(port_enabled_out), 8'H00);
        $display("test extra_pulse done");
        master_mode_in = 1'b0;
        cs_config_in[0] = '0;
        tick(1);
        pulse(enable_in);
        check(8'(receive_full_flag_out), 8'H01);
        pulse(disable_in);
        check(8'(port_enabled_out), 8'H01);
        cs_config_in[0].clock_polarity_setting = 1'b1;
        tick(2);
        cs_config_in[0].clock_polarity_setting = 1'b0;
        pulse(rx_read_in);
        check(8'(receive_full_flag_out), 8'H00);
        for (int k = 0; k < 2; k++)
        begin
            tx_data_in = 8'($urandom);
            pulse(tx_write_in);
            check(8'(tx_empty_out), 8'H00);
            b = 8'($urandom);
            i_peer.send(b);
            tick(4);
            check(8'(tx_empty_out), 8'H01);
            check(receive_holding_register_out, b);
            check(got, tx_data_in);
            pulse(rx_read_in);
        end
        pulse(soft_reset_in);
        check(8'(port_enabled_out), 8'H00);
        $display("test slave done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
